// >>> hw/psbs_defines.svh
// constants for the pipelined burst memory block
`ifndef PSBS_DEFINES_SVH
`define PSBS_DEFINES_SVH
`define PSBS_WIDE_DATA 36
`define PSBS_WIDE_ADDR 18
`define PSBS_NARROW_DATA 18
`define PSBS_NARROW_ADDR 19
`define PSBS_LANE_BITS 9
`define PSBS_BURST_MASK 2'h3
`define PSBS_BURST_ONE 2'h1
`define PSBS_PIPE_ZERO 2'h0
`define PSBS_CLK_MHZ 20
`define PSBS_MAX_MHZ 250
`endif

// >>> hw/psbs_pkg.sv
// types for the pipelined burst memory block
package psbs_pkg;
    typedef enum logic [2:0] {
        PSBS_IDLE  = 3'b001,
        PSBS_READ  = 3'b010,
        PSBS_WRITE = 3'b100
    } psbs_op_t;
endpackage

// >>> hw/psbs_mem.sv
// pipelined synchronous burst memory with three-stage read and write pipes
// ============================================================
// What this block does
// - all synchronous inputs are captured on the rising clock edge
// - read data leaves through output registers on the rising edge
// - clock gate low freezes every pipeline stage and data output for that edge; sleep and reset sync still run
// - three chip selects qualify access; output enable pin is not read, drivers are gated in the pad wrapper
// - drivers are off during the data phase of every write
// - reads and writes follow back to back with no idle cycles
// - output buffer control is internal, no output enable toggling needed
// - bursts step addresses in linear or interleaved order by mode input
// - sleep input enters low power; stopped clock is tolerated
// - array is 256K by 36 or 512K by 18 words
// - zero wait states up to the fastest clock grade
`timescale 1ns/10ps
`include "psbs_defines.svh"
`default_nettype none
module psbs_mem
    import psbs_pkg::*;
#(
    parameter int DW = `PSBS_WIDE_DATA,
    parameter int AW = `PSBS_WIDE_ADDR,
    parameter int BW = DW / `PSBS_LANE_BITS
) (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic clock_gate_n_i,
    input wire logic chip_select_first_n_i,
    input wire logic chip_select_second_i,
    input wire logic chip_select_third_n_i,
    input wire logic output_enable_n_i,
    input wire logic write_n_i,
    input wire logic advance_i,
    input wire logic [BW-1:0] byte_write_n_i,
    input wire logic [AW-1:0] addr_i,
    input wire logic linear_mode_i,
    input wire logic sleep_request_i,
    input wire logic [DW-1:0] data_i,
    output logic [DW-1:0] data_o,
    output logic [DW-1:0] data_oe_o,
    output logic sleep_o
);
    // ============================================================
    // burst sequencing
    function automatic logic [1:0] burst_next(input logic [1:0] start,
                                              input logic [1:0] cnt,
                                              input logic lin);
        if (lin) begin
            burst_next = start + cnt;
        end else begin
            burst_next = start ^ cnt;
        end
    endfunction

    // byte lanes of nine bits; a low write select takes the new lane
    function automatic logic [DW-1:0] lane_merge(input logic [DW-1:0] old,
                                                 input logic [DW-1:0] nw,
                                                 input logic [BW-1:0] bsel_n);
        lane_merge = old;
        for (int b = 0; b < BW; b++) begin
            if (!bsel_n[b]) begin
                lane_merge[b*`PSBS_LANE_BITS +: `PSBS_LANE_BITS] =
                    nw[b*`PSBS_LANE_BITS +: `PSBS_LANE_BITS];
            end
        end
    endfunction

    typedef struct packed {
        logic [1:0] rst_sync;
        logic [2:0] sleep_sync;
        logic sleep;
        psbs_op_t op1;
        psbs_op_t op2;
        logic [AW-1:0] addr1;
        logic [AW-1:0] addr2;
        logic [1:0] start;
        logic [1:0] cnt;
        psbs_op_t op3;
        logic [AW-1:0] addr3;
        logic burst_lin;
        logic [DW-1:0] dout;
        logic drive;
        logic [DW-1:0] oe;
    } psbs_state_t;

    // ============================================================
    // storage and state
    // stage 1 holds the address, stage 2 reads, stage 3 is the data slot
    logic [DW-1:0] mem_q [0:(1<<AW)-1];
    psbs_state_t s_q;
    psbs_state_t s_d;
    logic rst_n;
    logic sel;
    logic [AW-1:0] burst_addr;

    assign rst_n = s_q.rst_sync[1];

    assign sel = !chip_select_first_n_i && chip_select_second_i &&
                 !chip_select_third_n_i;
    assign burst_addr = {s_q.addr1[AW-1:2],
                         burst_next(s_q.start, s_q.cnt + `PSBS_BURST_ONE,
                                    s_q.burst_lin)};

    // ============================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.rst_sync = {s_q.rst_sync[0], 1'h1};
        // sleep pin is asynchronous: the two oldest of three stages must agree
        s_d.sleep_sync = {s_q.sleep_sync[1:0], sleep_request_i};
        if (s_q.sleep_sync[2] == s_q.sleep_sync[1]) begin
            s_d.sleep = s_q.sleep_sync[2];
        end
        if (!clock_gate_n_i) begin
            // hold every stage as if the last cycle were stretched
            s_d.op1 = s_q.op1;
        end else if (s_q.sleep) begin
            s_d.op1 = PSBS_IDLE;
            s_d.op2 = PSBS_IDLE;
            // a write caught in its slot is dropped, not deferred
            s_d.op3 = PSBS_IDLE;
            s_d.drive = 1'b0;
            s_d.oe = '0;
        end else begin
            // stage 1: capture command and address
            if (advance_i) begin
                if (s_q.op1 != PSBS_IDLE) begin
                    s_d.addr1 = burst_addr;
                    s_d.cnt = s_q.cnt + `PSBS_BURST_ONE;
                end
            end else if (sel) begin
                s_d.op1 = write_n_i ? PSBS_READ : PSBS_WRITE;
                s_d.addr1 = addr_i;
                s_d.start = addr_i[1:0];
                s_d.cnt = `PSBS_PIPE_ZERO;
                s_d.burst_lin = linear_mode_i;
            end else begin
                s_d.op1 = PSBS_IDLE;
            end
            // stage 2 carries the access one more enabled edge
            s_d.op2 = s_q.op1;
            s_d.addr2 = s_q.addr1;
            // stage 3: the data slot, where write data is due
            s_d.op3 = s_q.op2;
            s_d.addr3 = s_q.addr2;
            // read data registered out on the second edge
            // a write slot leaves drive low, so no contention
            s_d.drive = (s_q.op2 == PSBS_READ);
            s_d.oe = {DW{s_d.drive}};
            if (s_q.op2 == PSBS_READ) begin
                s_d.dout = mem_q[s_q.addr2];
                // forwarding costs a comparator but saves a wait cycle
                // when a read follows a write to the same word
                if (s_q.op3 == PSBS_WRITE && s_q.addr3 == s_q.addr2) begin
                    s_d.dout = lane_merge(s_d.dout, data_i, byte_write_n_i);
                end
            end
        end
    end

    // array write: data is taken in the slot after the second edge
    // a gated edge leaves the slot open, so the write waits with it
    always_ff @(posedge clk_i) begin
        if (clock_gate_n_i && !s_q.sleep && rst_n &&
            s_q.op3 == PSBS_WRITE) begin
            mem_q[s_q.addr3] <= lane_merge(mem_q[s_q.addr3], data_i,
                                           byte_write_n_i);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_q.rst_sync <= 2'h0;
            s_q.sleep_sync <= 3'h0;
            s_q.sleep <= 1'b0;
            s_q.op1 <= PSBS_IDLE;
            s_q.op2 <= PSBS_IDLE;
            s_q.addr1 <= '0;
            s_q.addr2 <= '0;
            s_q.start <= `PSBS_PIPE_ZERO;
            s_q.cnt <= `PSBS_PIPE_ZERO;
            s_q.op3 <= PSBS_IDLE;
            s_q.addr3 <= '0;
            s_q.burst_lin <= 1'b0;
            s_q.dout <= '0;
            s_q.drive <= 1'b0;
            s_q.oe <= '0;
        end else if (!rst_n) begin
            s_q.rst_sync <= s_d.rst_sync;
            s_q.sleep_sync <= 3'h0;
        end else begin
            s_q.sleep_sync <= s_d.sleep_sync;
            s_q.sleep <= s_d.sleep;
            s_q.op1 <= s_d.op1;
            s_q.op2 <= s_d.op2;
            s_q.addr1 <= s_d.addr1;
            s_q.addr2 <= s_d.addr2;
            s_q.start <= s_d.start;
            s_q.cnt <= s_d.cnt;
            s_q.rst_sync <= s_d.rst_sync;
            s_q.op3 <= s_d.op3;
            s_q.addr3 <= s_d.addr3;
            s_q.burst_lin <= s_d.burst_lin;
            s_q.dout <= s_d.dout;
            s_q.drive <= s_d.drive;
            s_q.oe <= s_d.oe;
        end
    end

    // ============================================================
    // outputs; async output enable applied by the pad wrapper
    // boundary scan lives in the pad ring, outside this core
    // the output enable pin is therefore not read inside the core
    assign data_o = s_q.dout;
    assign data_oe_o = s_q.oe;
    assign sleep_o = s_q.sleep;
endmodule
`default_nettype wire

// >>> dv/psbs_mem_checker.sv
// pin-level assertions for the pipelined burst memory
`timescale 1ns/10ps
`default_nettype none
module psbs_mem_checker
    import psbs_pkg::*;
#(parameter int DW = 36) (
    input wire logic clk_i, rst_n_i, clock_gate_n_i, write_n_i, advance_i,
    input wire logic chip_select_first_n_i, chip_select_second_i,
    input wire logic chip_select_third_n_i, sleep_request_i, sleep_o,
    input wire logic [DW-1:0] data_o, data_oe_o
);
    logic sel;
    assign sel = !chip_select_first_n_i && chip_select_second_i &&
        !chip_select_third_n_i && clock_gate_n_i && !sleep_o;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);
    sequence s_rd; sel && !advance_i && write_n_i; endsequence
    sequence s_wr; sel && !advance_i && !write_n_i; endsequence
    // ========
    // pipeline, turnaround, gating, deselect and sleep
    rd_drive_a: assert property (s_rd ##1 clock_gate_n_i [*2]
        |=> data_oe_o == '1) else $error("read not driven");
    wr_hiz_a: assert property (s_wr ##1 clock_gate_n_i [*2]
        |=> data_oe_o == '0) else $error("write slot driven");
    turn_around_a: assert property (s_rd ##1 s_wr ##1
        clock_gate_n_i [*2] |-> data_oe_o == '1 ##1 data_oe_o == '0)
        else $error("turnaround wrong");
    burst_step_a: assert property (s_rd ##1 clock_gate_n_i && advance_i
        ##1 clock_gate_n_i [*2] |=> data_oe_o == '1) else $error("burst");
    gate_hold_a: assert property (!clock_gate_n_i |=> $stable(data_o)
        && $stable(data_oe_o)) else $error("gated edge moved outputs");
    desel_idle_a: assert property ((clock_gate_n_i && !advance_i
        && !sel) [*4] |-> data_oe_o == '0) else $error("idle driven");
    sleep_in_a: assert property ($rose(sleep_request_i)
        |-> ##[1:6] sleep_o) else $error("no sleep");
    sleep_out_a: assert property (!sleep_request_i [*8]
        |-> !sleep_o) else $error("stuck asleep");
endmodule
`default_nettype wire

// >>> dv/psbs_ctl_model.sv
// controller model: write data in the slot two enabled edges on
`timescale 1ns/10ps
`default_nettype none
module psbs_ctl_model (
    input wire logic clk_i,
    input wire logic wr_cmd_i,
    input wire logic clock_gate_n_i,
    input wire logic [17:0] addr_i,
    output logic [35:0] data_o,
    output logic [3:0] byte_write_n_o
);
    logic [2:0] pend_q = 3'h0;
    logic [17:0] addr_q [0:2];
    logic [35:0] bus_q = 36'h0;
    logic [3:0] bw_q = 4'hf;
    always @(posedge clk_i) begin
        if (clock_gate_n_i) begin
            pend_q <= {pend_q[1:0], wr_cmd_i};
            addr_q[0] <= addr_i;
            addr_q[1] <= addr_q[0];
            addr_q[2] <= addr_q[1];
        end
    end
    // a released bus shows the inverse, so no stale match
    always @(negedge clk_i) begin
        bus_q <= pend_q[2] ? {addr_q[2], ~addr_q[2]} : ~bus_q;
        bw_q <= pend_q[2] ? 4'h0 : 4'hf;
    end
    assign data_o = bus_q;
    assign byte_write_n_o = bw_q;
endmodule
`default_nettype wire

// >>> dv/tb.sv
// self-checking bench for the pipelined burst memory
`timescale 1ns/10ps
`default_nettype none
module tb;
    import psbs_pkg::*;
    logic clk_i = 0, rst_n_i = 0, gate = 1, lin = 1, slp = 0, wc = 0;
    logic c1 = 1, c2 = 0, c3 = 1, wn = 1, adv = 0, sleep;
    logic [2:0] ds = 3'h0;
    logic [17:0] ad = '0, e;
    logic [35:0] wd, rd_q, oe;
    logic [3:0] be;
    int err_total = 0, num_checks = 0;
    psbs_mem psbs_mem_i (.clk_i(clk_i), .rst_n_i(rst_n_i),
        .clock_gate_n_i(gate), .chip_select_first_n_i(c1),
        .chip_select_second_i(c2), .chip_select_third_n_i(c3),
        .output_enable_n_i(1'b0), .write_n_i(wn), .advance_i(adv),
        .byte_write_n_i(be), .addr_i(ad), .linear_mode_i(lin),
        .sleep_request_i(slp), .data_i(wd), .data_o(rd_q),
        .data_oe_o(oe), .sleep_o(sleep));
    psbs_ctl_model psbs_ctl_model_i (.clk_i(clk_i), .wr_cmd_i(wc),
        .clock_gate_n_i(gate), .addr_i(ad), .data_o(wd),
        .byte_write_n_o(be));
    // ========
    // access tasks
    task automatic chk(input logic [35:0] got, input logic [35:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("unexpected at %0t: %h not %h", $time, got, exp);
        end
    endtask
    // k: 0 idle, 1 read, 2 write, 3 burst advance
    task automatic op(input logic [1:0] k, input logic [17:0] a);
        @(negedge clk_i);
        c1 = !(k[0] ^ k[1]) ^ ds[0];
        c2 = (k[0] ^ k[1]) ^ ds[1];
        c3 = !(k[0] ^ k[1]) ^ ds[2];
        wn = k != 2'h2;
        wc = k == 2'h2;
        adv = k == 2'h3;
        ad = a;
    endtask
    task automatic rd(input logic [17:0] a);
        op(2'h1, a);
        op(2'h0, a);
        op(2'h0, a);
        @(negedge clk_i);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    initial forever #25 clk_i = ~clk_i;
    initial begin
        #100000;
        err_total++;
        tally_and_finish();
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rst_n_i = 1;
        repeat (3) op(2'h0, '0);
        for (int i = 8; i < 12; i++) op(2'h2, 18'(i));
        op(2'h2, 18'h0_0021);
        rd(18'h0_0021);
        chk(rd_q, {18'h0_0021, ~18'h0_0021});
        op(2'h1, 18'h0_000a);
        op(2'h2, 18'h0_0031);
        rd(18'h0_0031);
        chk(rd_q, {18'h0_0031, ~18'h0_0031});
        $display("test read write done");
        for (int m = 0; m < 2; m++) begin
            lin = m[0];
            op(2'h1, 18'h0_0009);
            op(2'h3, '0);
            op(2'h3, '0);
            for (int k = 0; k < 4; k++) begin
                op(k == 0 ? 2'h3 : 2'h0, '0);
                e = 18'h0_0008 | 18'(m ? (1 + k) % 4 : 1 ^ k);
                chk(rd_q, {e, ~e});
            end
        end
        $display("test burst done");
        op(2'h1, 18'h0_000b);
        op(2'h0, '0);
        gate = 0;
        op(2'h0, '0);
        op(2'h0, '0);
        gate = 1;
        op(2'h0, '0);
        op(2'h0, '0);
        chk(rd_q, {18'h0_000b, ~18'h0_000b});
        chk(oe, 36'hf_ffff_ffff);
        for (int s = 0; s < 3; s++) begin
            ds = 3'h1 << s;
            rd(18'h0_0009);
            chk(oe, 36'h0);
        end
        ds = 3'h0;
        slp = 1;
        repeat (8) op(2'h0, '0);
        chk({35'h0, sleep}, 36'h1);
        rd(18'h0_0009);
        chk(oe, 36'h0);
        slp = 0;
        repeat (8) op(2'h0, '0);
        chk({35'h0, sleep}, 36'h0);
        $display("test gate select sleep done");
        tally_and_finish();
    end
endmodule
bind psbs_mem psbs_mem_checker #(.DW(DW)) psbs_mem_checker_i (.*);
`default_nettype wire
